// File: verilog/hvc1_top.sv
// Second high-voltage configuration register and the control it drives
`default_nettype none
`timescale 1ns/10ps
`include "hvc1_defines.svh"

module hvc1_top #(
   parameter int unsigned WAKE_SHORT_CYC = `HVC1_WAKE_SHORT_CYC,
   parameter int unsigned WAKE_TMO_CYC = `HVC1_WAKE_TMO_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Command and data port
   input wire logic i_cmd_strobe,
   input wire logic [`HVC1_CMD_W-1:0] i_cmd_code,
   input wire logic [`HVC1_REG_W-1:0] i_cmd_data,
   output logic o_busy,
   output logic o_rd_valid,
   output logic [`HVC1_CMD_W+`HVC1_REG_W-1:0] o_rd_data,
   // Pins and analog event inputs
   input wire logic i_wake_pin,
   input wire logic i_lin_short_raw,
   input wire logic i_wake_short_raw,
   input wire logic i_thermal_event,
   // From the first configuration register and status logic
   input wire logic i_wake_assert,
   input wire logic i_wake_thermal_off,
   input wire logic i_edge_ack,
   // Analog and pin controls
   output logic o_atten_en,
   output logic o_temp_mon_en,
   output logic o_vchan_short_en,
   output logic o_wake_input_en,
   output logic o_wake_pullup_en,
   output logic o_lin_enable,
   output logic o_wake_enable,
   output logic o_wake_drive,
   // Status toward the interrupt and monitor logic
   output logic o_mon_wake_level,
   output logic o_stat_lin_short,
   output logic o_stat_wake_short,
   output logic o_stat_wake_edge,
   output logic o_hv_irq
);

   hvc1_pkg::hvc1_state_t q;
   hvc1_pkg::hvc1_state_t d;
   logic lin_fire;
   logic wake_fire;

   hvc1_short_filter #(
      .LIMIT(`HVC1_LIN_SHORT_CYC)
   ) u_lin_filt (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_raw(q.lin_sync[1]),
      .o_fire(lin_fire)
   );

   hvc1_short_filter #(
      .LIMIT(WAKE_SHORT_CYC)
   ) u_wake_filt (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_raw(q.wsh_sync[1]),
      .o_fire(wake_fire)
   );

   always_comb
   begin
      d = q;
      d.rd_valid = 1'b0;

      // Pin synchronisers, second stage only is read
      d.wake_sync = {q.wake_sync[0], i_wake_pin};
      d.lin_sync = {q.lin_sync[0], i_lin_short_raw};
      d.wsh_sync = {q.wsh_sync[0], i_wake_short_raw};
      d.th_sync = {q.th_sync[0], i_thermal_event};
      d.wake_prev = q.wake_sync[1];
      d.th_prev = q.th_sync[1];

      // Command handling
      unique case (q.st)
         hvc1_pkg::HVC1_IDLE:
         begin
            if (i_cmd_strobe && (i_cmd_code == `HVC1_CMD_RD_CFG1
                                 || i_cmd_code == `HVC1_CMD_WR_CFG1))
            begin
               d.st = hvc1_pkg::HVC1_BUSY;
               d.lat = `HVC1_LAT_CYC;
               d.cmd = i_cmd_code;
               d.wdata = i_cmd_data;
               d.busy = 1'b1;
            end
         end
         hvc1_pkg::HVC1_BUSY:
         begin
            d.lat = q.lat - `HVC1_LAT_W'(1);
            if (q.lat == `HVC1_LAT_W'(1))
            begin
               d.st = hvc1_pkg::HVC1_IDLE;
               d.busy = 1'b0;
               d.rd_valid = 1'b1;
               if (q.cmd == `HVC1_CMD_WR_CFG1)
               begin
                  d.cfg = q.wdata;
                  d.rd_data = {q.cmd, q.wdata};
                  if (q.wdata[`HVC1_B_REARM])
                  begin
                     // Re-enable pins and clear short flags
                     d.lin_en = 1'b1;
                     d.wake_en = 1'b1;
                     d.lin_flag = 1'b0;
                     d.wake_flag = 1'b0;
                  end
               end
               else
               begin
                  d.rd_data = {q.cmd, q.cfg};
               end
            end
         end
      endcase

      // Short events set after the clear so a same-cycle event wins
      if (lin_fire)
      begin
         d.lin_flag = 1'b1;
         if (!q.cfg[`HVC1_B_PASSIVE])
         begin
            d.lin_en = 1'b0;
         end
      end
      if (wake_fire)
      begin
         d.wake_flag = 1'b1;
         d.wake_en = 1'b0;
      end
      if (q.th_sync[1] && !q.th_prev && !i_wake_thermal_off)
      begin
         d.wake_en = 1'b0;
      end

      // Wake-pin edge detection while input is enabled
      if (i_edge_ack)
      begin
         d.edge_flag = 1'b0;
      end
      if (q.cfg[`HVC1_B_WAKE_IN] && (q.wake_sync[1] != q.wake_prev))
      begin
         d.edge_flag = 1'b1;
      end
      d.mon_wake = q.cfg[`HVC1_B_WAKE_IN] & q.wake_sync[1];
      d.irq = d.lin_flag | d.wake_flag | d.edge_flag;

      // Wake output time-out
      if (!i_wake_assert || q.cfg[`HVC1_B_TMO_OFF])
      begin
         d.tmo_cnt = '0;
         d.tmo_done = 1'b0;
      end
      else if (!q.tmo_done)
      begin
         if (q.tmo_cnt == `HVC1_TMO_W'(WAKE_TMO_CYC - 1))
         begin
            d.tmo_done = 1'b1;
         end
         else
         begin
            d.tmo_cnt = q.tmo_cnt + `HVC1_TMO_W'(1);
         end
      end
      d.wake_drive = i_wake_assert & d.wake_en & ~d.tmo_done;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         q <= '0;
         q.st <= hvc1_pkg::HVC1_IDLE;
         q.cfg <= `HVC1_CFG_RESET;
         q.lin_en <= 1'b1;
         q.wake_en <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from state flops
   assign o_busy = q.busy;
   assign o_rd_valid = q.rd_valid;
   assign o_rd_data = q.rd_data;
   assign o_atten_en = q.cfg[`HVC1_B_ATTEN];
   assign o_temp_mon_en = q.cfg[`HVC1_B_TEMPMON];
   assign o_vchan_short_en = q.cfg[`HVC1_B_VSHORT];
   assign o_wake_input_en = q.cfg[`HVC1_B_WAKE_IN];
   assign o_wake_pullup_en = q.cfg[`HVC1_B_PULLUP];
   assign o_lin_enable = q.lin_en;
   assign o_wake_enable = q.wake_en;
   assign o_wake_drive = q.wake_drive;
   assign o_mon_wake_level = q.mon_wake;
   assign o_stat_lin_short = q.lin_flag;
   assign o_stat_wake_short = q.wake_flag;
   assign o_stat_wake_edge = q.edge_flag;
   assign o_hv_irq = q.irq;

endmodule : hvc1_top

`default_nettype wire

// File: verilog/hvc1_defines.svh
// Constants for the second high-voltage configuration register block
`ifndef HVC1_DEFINES_SVH
`define HVC1_DEFINES_SVH

// Command codes carried in the upper field of the data port
`define HVC1_CMD_W 4
`define HVC1_CMD_RD_CFG1 4'h1
`define HVC1_CMD_WR_CFG1 4'h9

// Register width and reset value
`define HVC1_REG_W 8
`define HVC1_CFG_RESET 8'h00

// Field positions
`define HVC1_B_ATTEN 7
`define HVC1_B_TEMPMON 6
`define HVC1_B_VSHORT 5
`define HVC1_B_WAKE_IN 4
`define HVC1_B_REARM 3
`define HVC1_B_PASSIVE 2
`define HVC1_B_TMO_OFF 1
`define HVC1_B_PULLUP 0

// Clock rate and times in their own units
`define HVC1_CLK_MHZ 125
`define HVC1_LIN_SHORT_US 20
`define HVC1_WAKE_SHORT_US 400
`define HVC1_WAKE_TMO_MS 1300

// Times converted to clock cycles
`define HVC1_LIN_SHORT_CYC (`HVC1_LIN_SHORT_US * `HVC1_CLK_MHZ)
`define HVC1_WAKE_SHORT_CYC (`HVC1_WAKE_SHORT_US * `HVC1_CLK_MHZ)
`define HVC1_WAKE_TMO_CYC (`HVC1_WAKE_TMO_MS * 1000 * `HVC1_CLK_MHZ)

// Counter widths and command latency
`define HVC1_FILT_W 16
`define HVC1_TMO_W 28
`define HVC1_LAT_W 3
`define HVC1_LAT_CYC 3'h4
`define HVC1_SYNC_W 2

`endif

// File: verilog/hvc1_pkg.sv
// Types shared by the high-voltage configuration block
`default_nettype none
`include "hvc1_defines.svh"

package hvc1_pkg;

   typedef enum logic {HVC1_IDLE, HVC1_BUSY} hvc1_cmd_st_t;

   typedef struct packed {
      logic [`HVC1_FILT_W-1:0] cnt;
      logic fired;
      logic fire;
   } hvc1_filt_t;

   typedef struct packed {
      hvc1_cmd_st_t st;
      logic [`HVC1_LAT_W-1:0] lat;
      logic [`HVC1_CMD_W-1:0] cmd;
      logic [`HVC1_REG_W-1:0] wdata;
      logic busy;
      logic rd_valid;
      logic [`HVC1_CMD_W+`HVC1_REG_W-1:0] rd_data;
      logic [`HVC1_REG_W-1:0] cfg;
      logic [`HVC1_SYNC_W-1:0] wake_sync;
      logic [`HVC1_SYNC_W-1:0] lin_sync;
      logic [`HVC1_SYNC_W-1:0] wsh_sync;
      logic [`HVC1_SYNC_W-1:0] th_sync;
      logic wake_prev;
      logic th_prev;
      logic lin_en;
      logic wake_en;
      logic lin_flag;
      logic wake_flag;
      logic edge_flag;
      logic irq;
      logic mon_wake;
      logic [`HVC1_TMO_W-1:0] tmo_cnt;
      logic tmo_done;
      logic wake_drive;
   } hvc1_state_t;

endpackage : hvc1_pkg

`default_nettype wire

// File: verilog/hvc1_short_filter.sv
// Persistence filter that flags a short lasting longer than a cycle limit
`default_nettype none
`timescale 1ns/10ps
`include "hvc1_defines.svh"

module hvc1_short_filter #(
   parameter int unsigned LIMIT = `HVC1_LIN_SHORT_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_raw,
   output logic o_fire
);

   hvc1_pkg::hvc1_filt_t q;
   hvc1_pkg::hvc1_filt_t d;

   always_comb
   begin
      d = q;
      d.fire = 1'b0;
      if (i_raw)
      begin
         if (q.cnt < `HVC1_FILT_W'(LIMIT))
         begin
            d.cnt = q.cnt + `HVC1_FILT_W'(1);
         end
         else if (!q.fired)
         begin
            // One pulse per episode, once it outlasts the limit
            d.fire = 1'b1;
            d.fired = 1'b1;
         end
      end
      else
      begin
         d.cnt = '0;
         d.fired = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_fire = q.fire;

endmodule : hvc1_short_filter

`default_nettype wire

// File: verification/hvc1_cpu.sv
// Processor side model issuing register commands
`timescale 1ns/10ps
`default_nettype none
module hvc1_cpu (
   input wire logic i_clk_sys,
   input wire logic i_busy,
   input wire logic i_rd_valid,
   input wire logic [11:0] i_rd_data,
   output logic o_strobe,
   output logic [3:0] o_code,
   output logic [7:0] o_data
);
   initial o_strobe = 1'b0;
   initial o_code = 4'h5;
   initial o_data = 8'h5a;
   task automatic cmd(input logic [3:0] c, input logic [7:0] d, input int slow,
      output logic got, output logic [11:0] rd);
      got = 1'b0;
      rd = 12'h000;
      repeat (slow) @(negedge i_clk_sys);
      while (i_busy !== 1'b0) @(negedge i_clk_sys);
      o_strobe = 1'b1;
      o_code = c;
      o_data = d;
      @(negedge i_clk_sys);
      o_strobe = 1'b0;
      o_code = ~c;
      o_data = ~d;
      for (int k = 0; k < 8 && !got; k++)
      begin
         got = i_rd_valid === 1'b1;
         rd = i_rd_data;
         if (!got) @(negedge i_clk_sys);
      end
   endtask : cmd
endmodule : hvc1_cpu
`default_nettype wire

// File: verification/hvc1_asserts.sv
// Port checker for the configuration block
`timescale 1ns/10ps
`default_nettype none
module hvc1_asserts (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_cmd_strobe,
   input wire logic [3:0] i_cmd_code,
   input wire logic o_busy,
   input wire logic o_rd_valid,
   input wire logic [11:0] o_rd_data,
   input wire logic o_atten_en,
   input wire logic o_temp_mon_en,
   input wire logic o_vchan_short_en,
   input wire logic o_wake_input_en,
   input wire logic o_wake_pullup_en,
   input wire logic o_lin_enable,
   input wire logic o_mon_wake_level,
   input wire logic o_stat_lin_short,
   input wire logic o_stat_wake_short,
   input wire logic o_stat_wake_edge,
   input wire logic o_hv_irq
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   logic [4:0] cfg_o;
   logic take;
   logic ok_c;
   assign cfg_o = {o_atten_en, o_temp_mon_en, o_vchan_short_en, o_wake_input_en, o_wake_pullup_en};
   assign take = i_cmd_strobe && !o_busy;
   assign ok_c = i_cmd_code == 4'h1 || i_cmd_code == 4'h9;
   chk_busy_span: assert property (take && ok_c |=> o_busy [*4] ##1 (!o_busy && o_rd_valid))
      else $error("busy span");
   chk_bad_code: assert property (take && !ok_c |=> !o_busy)
      else $error("bad code taken");
   chk_echo_cfg: assert property (o_rd_valid |-> {o_rd_data[7:4], o_rd_data[0]} == cfg_o)
      else $error("echo differs");
   chk_cfg_hold: assert property (!o_rd_valid |-> $stable(cfg_o))
      else $error("cfg changed");
   chk_mon_gate: assert property (!o_wake_input_en |=> !o_mon_wake_level)
      else $error("monitor not gated");
   chk_irq_or: assert property (o_hv_irq == (o_stat_lin_short || o_stat_wake_short || o_stat_wake_edge))
      else $error("irq mismatch");
   chk_flag_clear: assert property ($fell(o_stat_lin_short) |-> o_rd_valid && o_rd_data[3])
      else $error("flag cleared alone");
   chk_lin_rearm: assert property ($rose(o_lin_enable) |-> o_rd_valid && o_rd_data[3])
      else $error("lin enabled alone");
endmodule : hvc1_asserts
bind hvc1_top hvc1_asserts i_hvc1_asserts (.*);
`default_nettype wire

// File: verification/hv_config_one_control_test.sv
// Self-checking bench for the configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module hv_config_one_control_test;
   logic clk = 0, nrst = 0, wk = 0, lsr = 0, wsr = 0, th = 0, was = 0, tho = 0, ack = 0;
   logic stb, bsy, rdv, att, tmo, vsh, win, pu, lin, wen, drv, mon, sl, sw, se, irq, got;
   logic [3:0] code;
   logic [7:0] dat;
   logic [11:0] rdd, rd;
   int n_fail = 0, samples_checked = 0, cfg = 0;
   hvc1_top #(.WAKE_SHORT_CYC(20), .WAKE_TMO_CYC(50)) i_hvc1_top (.i_clk_sys(clk), .i_nrst(nrst),
      .i_cmd_strobe(stb), .i_cmd_code(code), .i_cmd_data(dat), .o_busy(bsy), .o_rd_valid(rdv),
      .o_rd_data(rdd), .i_wake_pin(wk), .i_lin_short_raw(lsr), .i_wake_short_raw(wsr),
      .i_thermal_event(th), .i_wake_assert(was), .i_wake_thermal_off(tho), .i_edge_ack(ack),
      .o_atten_en(att), .o_temp_mon_en(tmo), .o_vchan_short_en(vsh), .o_wake_input_en(win),
      .o_wake_pullup_en(pu), .o_lin_enable(lin), .o_wake_enable(wen), .o_wake_drive(drv),
      .o_mon_wake_level(mon), .o_stat_lin_short(sl), .o_stat_wake_short(sw),
      .o_stat_wake_edge(se), .o_hv_irq(irq));
   hvc1_cpu i_hvc1_cpu (.i_clk_sys(clk), .i_busy(bsy), .i_rd_valid(rdv), .i_rd_data(rdd),
      .o_strobe(stb), .o_code(code), .o_data(dat));
   initial forever #4 clk = ~clk;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   task automatic wr(input logic [7:0] d);
      i_hvc1_cpu.cmd(4'h9, d, $urandom % 3, got, rd);
      cfg = d;
      `CHK("write done", 1'b1, got)
      `CHK("write echo", {4'h9, d}, rd)
      `CHK("cfg pins", {d[7:4], d[0]}, {att, tmo, vsh, win, pu})
   endtask : wr
   task automatic rb();
      i_hvc1_cpu.cmd(4'h1, 8'h00, $urandom % 3, got, rd);
      `CHK("read done", 1'b1, got)
      `CHK("read back", {4'h1, cfg[7:0]}, rd)
   endtask : rb
   initial
   begin
      #100000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      void'($urandom(91802));
      wt(20);
      nrst = 1;
      rb();
      repeat (6)
      begin
         wr(8'($urandom));
         rb();
      end
      // Even codes only: neither read nor write
      for (int c = 0; c < 16; c += 2)
      begin
         i_hvc1_cpu.cmd(4'(c), 8'hff, 0, got, rd);
         `CHK("bad code", 1'b0, got)
      end
      rb();
      for (int p = 0; p < 2; p++)
      begin
         wr(8'(p * 4));
         lsr = 1;
         wt(2490);
         `CHK("short early", 1'b0, sl)
         wt(30);
         `CHK("lin short", {2'b11, 1'(p)}, {sl, irq, lin})
         lsr = 0;
         wt(9);
         `CHK("sticky", 2'b11, {sl, irq})
         wr(8'(8 + p * 4));
         `CHK("rearm", 3'b001, {sl, irq, lin})
      end
      wsr = 1;
      wt(18);
      `CHK("wake short early", 1'b0, sw)
      wt(12);
      `CHK("wake short", 3'b110, {sw, irq, wen})
      wsr = 0;
      wr(8'h08);
      `CHK("wake rearm", 2'b01, {sw, wen})
      th = 1;
      wt(6);
      `CHK("thermal", 1'b0, wen)
      th = 0;
      wr(8'h18);
      `CHK("thermal rearm", 1'b1, wen)
      tho = 1;
      th = 1;
      wt(6);
      `CHK("thermal masked", 1'b1, wen)
      th = 0;
      tho = 0;
      wk = 1;
      wt(8);
      `CHK("edge", 3'b111, {se, irq, mon})
      wr(8'h00);
      wk = 0;
      ack = 1;
      wt(1);
      ack = 0;
      wt(8);
      `CHK("no edge", 3'b000, {se, irq, mon})
      was = 1;
      wt(4);
      `CHK("drive on", 1'b1, drv)
      wt(40);
      `CHK("drive held", 1'b1, drv)
      wt(20);
      `CHK("drive timeout", 1'b0, drv)
      wr(8'h02);
      wt(2);
      `CHK("drive kept", 1'b1, drv)
      finish_test();
   end
endmodule : hv_config_one_control_test
`default_nettype wire
